// File: pkg/cst_defines.vh
// Purpose: Constants for the clock source start-up and trim block
// Assumes: 40 MHz system clock; fuse codes with 0 meaning programmed
// Notes: Register offsets are byte addresses on a 32-bit Wishbone bus
`ifndef CST_DEFINES_VH
`define CST_DEFINES_VH

// Source select fuse codes
`define CST_SRC_EXT 4'h0
`define CST_SRC_RC 4'h2
`define CST_SRC_LF_LO 4'h6
`define CST_SRC_LF_HI 4'h7

// Start-up time fuse codes
`define CST_SUT_14 2'h0
`define CST_SUT_4K 2'h1
`define CST_SUT_64K 2'h2
`define CST_SUT_RSVD 2'h3

// Shipped fuse defaults
`define CST_DEF_SRC 4'h2
`define CST_DEF_SUT 2'h2
`define CST_DEF_DIV8 1'b1

// Source cycle counts
`define CST_RESET_CK 20'h0000e
`define CST_WAKE_RC_CK 20'h00006
`define CST_WAKE_LF_LO_CK 20'h00400
`define CST_WAKE_LF_HI_CK 20'h08000

// Watchdog oscillator cycle counts for reset time-outs
`define CST_WDT_4K 20'h01000
`define CST_WDT_64K 20'h10000

// Register byte offsets
`define CST_REG_TRIM 4'h0
`define CST_REG_STATUS 4'h4
`define CST_REG_CTRL 4'h8

// Status register fields
`define CST_ST_READY 0
`define CST_ST_RC 1
`define CST_ST_LF 2
`define CST_ST_EXT 3
`define CST_ST_DIV8 4
`define CST_ST_BADCFG 5
`define CST_ST_TOSC 6
`define CST_ST_SRC_LSB 8
`define CST_ST_SUT_LSB 12

// Control register fields
`define CST_CT_WAKE 0

// Trim range and nominal-plus-ten-percent guide
`define CST_TRIM_MAX 7'h7f
`define CST_TRIM_MID 7'h3f

`endif

// File: hdl/cst_sync_count.v
// Purpose: Synchronises an external tick and counts its rising edges
// Assumes: Tick is slower than half the system clock
// Notes: Counter clears on i_clear and saturates at all ones
`timescale 1ns/1ps

module cst_sync_count #(
	parameter WIDTH = 20
) (
	// Clock and reset
	input wire i_sys_clk,
	input wire i_rstn,
	input wire i_ce,
	// Tick and control
	input wire i_tick,
	input wire i_clear,
	// Result
	output reg [WIDTH-1:0] o_count
);

	reg sync1;
	reg sync2;
	reg last;

	always @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			sync1 <= 1'b0;
			sync2 <= 1'b0;
			last <= 1'b0;
			o_count <= {WIDTH{1'b0}};
		end else if (i_ce) begin
			sync1 <= i_tick;
			sync2 <= sync1;
			last <= sync2;
			if (i_clear)
				o_count <= {WIDTH{1'b0}};
			else if (sync2 && !last && o_count != {WIDTH{1'b1}})
				o_count <= o_count + {{(WIDTH-1){1'b0}}, 1'b1};
		end
	end

endmodule

// File: hdl/cst_clock_startup.v
// Purpose: Clock source decode, start-up delay gating and oscillator trim
// Assumes: Fuses static while i_rstn is low; oscillator ticks are async pins
// Notes: Wishbone classic slave, 32-bit data, one wait state per access
`timescale 1ns/1ps
`include "cst_defines.vh"

// Functional notes
// - Fuse codes 0110/0111 select low-frequency crystal
// - Crystal reset delay 14 cycles plus 0/4K/64K
// - Crystal wake delay 1K or 32K cycles
// - Fuse code 0010 selects 8 MHz RC
// - Divide-by-eight fuse divides RC at start-up
// - Reset loads factory calibration into trim
// - Watchdog oscillator times reset time-out always
// - RC wake 6 cycles, reset delays as crystal
// - RC source frees crystal pins for timer
// - Trim register holds seven bits, retunes immediately
// - Trim zero slowest, rising monotonic to maximum
// - Trim codes span 50 to 200 percent
// - Code 0000 selects external clock on crystal pin
// - Shipped defaults RC, code 10, divide enabled
// - Reset time-outs are 4096/65536 watchdog cycles
module cst_clock_startup #(
	parameter CNT_W = 20,
	parameter [7:0] FACTORY_TRIM = 8'h40,
	parameter [CNT_W-1:0] WDT_4K = `CST_WDT_4K,
	parameter [CNT_W-1:0] WDT_64K = `CST_WDT_64K
) (
	// Clock, reset and enable
	input wire i_sys_clk,
	input wire i_rstn,
	input wire i_ce,
	// Fuses, unprogrammed bit reads as 1
	input wire [3:0] i_clock_source_select_fuses,
	input wire [1:0] i_startup_time_fuses,
	input wire i_divide_by_eight_fuse,
	input wire i_fuse_valid,
	// Oscillator ticks from pins and analogue blocks
	input wire i_src_tick,
	input wire i_wdt_tick,
	// Sleep wake request
	input wire i_wake_req,
	// Wishbone slave
	input wire i_wb_cyc,
	input wire i_wb_stb,
	input wire i_wb_we,
	input wire [3:0] i_wb_adr,
	input wire [3:0] i_wb_sel,
	input wire [31:0] i_wb_dat,
	output reg [31:0] o_wb_dat,
	output wire o_wb_ack,
	output wire o_wb_err,
	// Clock control outputs
	output reg o_core_clk_en,
	output reg o_sel_lf_crystal,
	output reg o_sel_rc,
	output reg o_sel_ext,
	output reg o_div8,
	output reg o_crystal_pins_to_timer,
	output reg o_wdt_for_timeout,
	output reg [6:0] o_trim_value
);

	localparam ST_LATCH = 5'h01;
	localparam ST_SRC = 5'h02;
	localparam ST_WDT = 5'h04;
	localparam ST_RUN = 5'h08;
	localparam ST_WAKE = 5'h10;

	reg [4:0] state;
	reg [4:0] next_state;
	reg [3:0] src_sel;
	reg [1:0] startup_time_fuses;
	reg div8_fuse;
	reg bad_cfg;
	reg [CNT_W-1:0] src_target;
	reg [CNT_W-1:0] wdt_target;
	reg [CNT_W-1:0] wake_target;
	reg clr_cnt;
	reg ack_q;
	reg wake_sw;
	reg wake_s1;
	reg wake_s2;
	wire [CNT_W-1:0] src_count;
	wire [CNT_W-1:0] wdt_count;
	wire is_lf;
	wire is_rc;
	wire is_ext;
	wire wake_any;
	wire req;
	wire hit_trim;
	wire hit_stat;
	wire hit_ctrl;
	wire hit_any;
	wire [31:0] status_word;

	cst_sync_count #(.WIDTH(CNT_W)) u_src_cnt (
		.i_sys_clk(i_sys_clk),
		.i_rstn(i_rstn),
		.i_ce(i_ce),
		.i_tick(i_src_tick),
		.i_clear(clr_cnt),
		.o_count(src_count)
	);

	cst_sync_count #(.WIDTH(CNT_W)) u_wdt_cnt (
		.i_sys_clk(i_sys_clk),
		.i_rstn(i_rstn),
		.i_ce(i_ce),
		.i_tick(i_wdt_tick),
		.i_clear(clr_cnt),
		.o_count(wdt_count)
	);

	assign is_lf = (src_sel == `CST_SRC_LF_LO) || (src_sel == `CST_SRC_LF_HI);
	assign is_rc = (src_sel == `CST_SRC_RC);
	assign is_ext = (src_sel == `CST_SRC_EXT);

	// Wake request is a pin; two flops before use
	always @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			wake_s1 <= 1'b0;
			wake_s2 <= 1'b0;
		end else if (i_ce) begin
			wake_s1 <= i_wake_req;
			wake_s2 <= wake_s1;
		end
	end
	assign wake_any = wake_s2 || wake_sw;

	// Delay targets: fixed reset count, time-out and wake from latched fuses
	always @* begin
		src_target = `CST_RESET_CK;
		case (startup_time_fuses)
			`CST_SUT_4K: wdt_target = WDT_4K;
			`CST_SUT_64K: wdt_target = WDT_64K;
			default: wdt_target = {CNT_W{1'b0}};
		endcase
		if (src_sel == `CST_SRC_LF_HI)
			wake_target = `CST_WAKE_LF_HI_CK;
		else if (src_sel == `CST_SRC_LF_LO)
			wake_target = `CST_WAKE_LF_LO_CK;
		else
			wake_target = `CST_WAKE_RC_CK;
	end

	always @* begin
		next_state = state;
		clr_cnt = 1'b0;
		case (state)
			ST_LATCH: begin
				next_state = ST_SRC;
				clr_cnt = 1'b1;
			end
			ST_SRC: begin
				if (!bad_cfg && src_count >= src_target) begin
					next_state = ST_WDT;
					clr_cnt = 1'b1;
				end
			end
			ST_WDT: begin
				// Watchdog oscillator times the real-time part
				if (wdt_count >= wdt_target)
					next_state = ST_RUN;
			end
			ST_RUN: begin
				if (wake_any) begin
					next_state = ST_WAKE;
					clr_cnt = 1'b1;
				end
			end
			ST_WAKE: begin
				if (src_count >= wake_target)
					next_state = ST_RUN;
			end
			default: begin
				next_state = ST_LATCH;
				clr_cnt = 1'b1;
			end
		endcase
	end

	always @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			state <= ST_LATCH;
			src_sel <= `CST_DEF_SRC;
			startup_time_fuses <= `CST_DEF_SUT;
			div8_fuse <= `CST_DEF_DIV8;
			bad_cfg <= 1'b0;
			o_core_clk_en <= 1'b0;
			o_sel_lf_crystal <= 1'b0;
			o_sel_rc <= 1'b0;
			o_sel_ext <= 1'b0;
			o_div8 <= 1'b0;
			o_crystal_pins_to_timer <= 1'b0;
			o_wdt_for_timeout <= 1'b1;
		end else if (i_ce) begin
			state <= next_state;
			// Fuses sampled once after reset release
			if (state == ST_LATCH) begin
				if (i_fuse_valid) begin
					src_sel <= i_clock_source_select_fuses;
					startup_time_fuses <= i_startup_time_fuses;
					div8_fuse <= ~i_divide_by_eight_fuse;
				end
			end
			// Reserved source or start-up codes hold the core stopped
			bad_cfg <= !(is_lf || is_rc || is_ext) || (startup_time_fuses == `CST_SUT_RSVD);
			o_core_clk_en <= (next_state == ST_RUN);
			o_sel_lf_crystal <= is_lf;
			o_sel_rc <= is_rc;
			o_sel_ext <= is_ext;
			o_div8 <= is_rc && div8_fuse;
			o_crystal_pins_to_timer <= is_rc;
			o_wdt_for_timeout <= 1'b1;
		end
	end

	// Wishbone decode
	assign req = i_wb_cyc && i_wb_stb && !ack_q;
	assign hit_trim = (i_wb_adr == `CST_REG_TRIM);
	assign hit_stat = (i_wb_adr == `CST_REG_STATUS);
	assign hit_ctrl = (i_wb_adr == `CST_REG_CTRL);
	assign hit_any = hit_trim || hit_stat || hit_ctrl;
	assign o_wb_ack = ack_q && i_wb_cyc && i_wb_stb && hit_any;
	assign o_wb_err = ack_q && i_wb_cyc && i_wb_stb && !hit_any;

	assign status_word = {16'h0000, 2'b00, startup_time_fuses, src_sel, 1'b0,
		o_crystal_pins_to_timer, bad_cfg, o_div8, o_sel_ext,
		o_sel_lf_crystal, o_sel_rc, o_core_clk_en};

	always @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			ack_q <= 1'b0;
			o_wb_dat <= 32'h00000000;
			o_trim_value <= FACTORY_TRIM[6:0];
			wake_sw <= 1'b0;
		end else if (i_ce) begin
			ack_q <= req;
			// Factory calibration reloaded in ST_LATCH, the first state after reset release
			if (state == ST_LATCH)
				o_trim_value <= FACTORY_TRIM[6:0];
			else if (o_wb_ack && i_wb_we && hit_trim && i_wb_sel[0])
				o_trim_value <= i_wb_dat[6:0];
			if (o_wb_ack && i_wb_we && hit_ctrl && i_wb_sel[0])
				wake_sw <= i_wb_dat[`CST_CT_WAKE];
			else if (state == ST_WAKE)
				wake_sw <= 1'b0;
			if (req && !i_wb_we) begin
				if (hit_trim)
					o_wb_dat <= {25'h0000000, o_trim_value};
				else if (hit_stat)
					o_wb_dat <= status_word;
				else if (hit_ctrl)
					o_wb_dat <= {31'h00000000, wake_sw};
				else
					o_wb_dat <= 32'h00000000;
			end
		end
	end

	// Trim drives the analogue oscillator directly; higher code is faster.
	// Software must stay near nominal when writing non-volatile memory.

endmodule

// File: test/cst_clock_startup_properties.sv
// Purpose: Port checks for the clock start-up and trim block
// Assumes: Bound to cst_clock_startup, i_ce held high
// Notes: Bus answer, trim and decode relations
`timescale 1ns/1ps
module cst_startup_chk (
	// Clock and reset
	input wire i_sys_clk,
	input wire i_rstn,
	// Bus
	input wire i_wb_cyc,
	input wire i_wb_stb,
	input wire i_wb_we,
	input wire [3:0] i_wb_adr,
	input wire [3:0] i_wb_sel,
	input wire [31:0] i_wb_dat,
	input wire [31:0] o_wb_dat,
	input wire o_wb_ack,
	input wire o_wb_err,
	// Clock control
	input wire o_core_clk_en,
	input wire o_sel_lf_crystal,
	input wire o_sel_rc,
	input wire o_sel_ext,
	input wire o_div8,
	input wire o_crystal_pins_to_timer,
	input wire o_wdt_for_timeout,
	input wire [6:0] o_trim_value
);
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_rstn);
	sequence s_req;
		i_wb_cyc && i_wb_stb;
	endsequence
	sequence s_trim_wr;
		o_wb_ack && i_wb_we && i_wb_adr == 4'h0 && i_wb_sel[0];
	endsequence
	AST_ACK_CAUSE: assert property ($rose(o_wb_ack) |-> $past(i_wb_cyc && i_wb_stb))
		else $error("ack without request");
	AST_ACK_DROP: assert property (!i_wb_stb |-> !o_wb_ack && !o_wb_err)
		else $error("answer without strobe");
	AST_ERR_MAP: assert property (s_req ##0 o_wb_err |-> !(i_wb_adr inside {4'h0, 4'h4, 4'h8}))
		else $error("error on mapped address");
	AST_TRIM_WR: assert property (s_trim_wr |=> o_trim_value == $past(i_wb_dat[6:0]))
		else $error("trim not retuned by write");
	AST_TRIM_RD: assert property (o_wb_ack && !i_wb_we && i_wb_adr == 4'h0 |-> o_wb_dat == {25'h0, o_trim_value})
		else $error("trim read mismatch");
	AST_WDT: assert property (o_wdt_for_timeout)
		else $error("watchdog timing dropped");
	AST_PINS: assert property (o_crystal_pins_to_timer == o_sel_rc)
		else $error("timer pins not tied to rc");
	AST_DIV8: assert property (o_div8 |-> o_sel_rc)
		else $error("divide without rc");
	AST_ONE_SRC: assert property ($onehot0({o_sel_lf_crystal, o_sel_rc, o_sel_ext}))
		else $error("several sources selected");
	AST_EN_SRC: assert property (o_core_clk_en |-> o_sel_lf_crystal || o_sel_rc || o_sel_ext)
		else $error("core clock without source");
endmodule

bind cst_clock_startup cst_startup_chk chk_inst (.i_sys_clk, .i_rstn, .i_wb_cyc, .i_wb_stb, .i_wb_we,
	.i_wb_adr, .i_wb_sel, .i_wb_dat, .o_wb_dat, .o_wb_ack, .o_wb_err, .o_core_clk_en, .o_sel_lf_crystal,
	.o_sel_rc, .o_sel_ext, .o_div8, .o_crystal_pins_to_timer, .o_wdt_for_timeout, .o_trim_value);

// File: test/cst_clock_startup_tb.sv
// Purpose: Register and start-up sequence bench
// Assumes: Oscillator ticks at a quarter of the system clock
// Notes: Time-outs shortened to 8 and 16 ticks
`timescale 1ns/1ps
module cst_clock_startup_tb;
	logic sys_clk = 1'b0, rstn = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, fv = 1'b0, div = 1'b0, be;
	logic [1:0] startup_time_fuses = 2'h0, tc = 2'h0;
	logic [3:0] src = 4'h0, adr = 4'h0;
	logic [31:0] wd = 32'h0, rd;
	logic [3:0] cs [6] = '{4'h6, 4'h7, 4'h0, 4'h2, 4'h3, 4'h2};
	logic [1:0] cu [6] = '{2'h0, 2'h1, 2'h2, 2'h0, 2'h0, 2'h1};
	logic [2:0] ce [6] = '{3'h4, 3'h4, 3'h1, 3'h2, 3'h0, 3'h2};
	logic [31:0] tv [3] = '{32'hffff_ff7f, 32'h0000_0f00, 32'h0000_003f};
	wire [31:0] dat;
	wire ack, err, en, lf, rc, ext, d8, tp, wdt;
	wire [6:0] trim;
	integer err_count = 0, checked = 0, i, n;
	always #12.5 sys_clk = ~sys_clk;
	always @(posedge sys_clk) tc <= tc + 2'h1;
	cst_clock_startup #(.WDT_4K(20'h8), .WDT_64K(20'h10)) cst_clock_startup_inst (.i_sys_clk(sys_clk),
		.i_rstn(rstn), .i_ce(1'b1), .i_clock_source_select_fuses(src), .i_startup_time_fuses(startup_time_fuses),
		.i_divide_by_eight_fuse(div), .i_fuse_valid(fv), .i_src_tick(tc[1]), .i_wdt_tick(tc[1]),
		.i_wake_req(1'b0), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hf),
		.i_wb_dat(wd), .o_wb_dat(dat), .o_wb_ack(ack), .o_wb_err(err), .o_core_clk_en(en),
		.o_sel_lf_crystal(lf), .o_sel_rc(rc), .o_sel_ext(ext), .o_div8(d8), .o_crystal_pins_to_timer(tp),
		.o_wdt_for_timeout(wdt), .o_trim_value(trim));
	task chk(input string s, input logic [31:0] v, input logic [31:0] e);
		checked++;
		if (v !== e) begin
			err_count++;
			$display("wrong value %s exp %h got %h", s, e, v);
		end
	endtask
	task print_verdict;
		if (err_count == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		integer k;
		@(posedge sys_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wd <= d;
		for (k = 0; k < 20 && !(ack || err); k++) @(negedge sys_clk);
		if (k == 20) begin
			err_count++;
			print_verdict;
		end
		be = err;
		@(posedge sys_clk);
		rd = dat;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(negedge sys_clk);
	endtask
	task boot(input logic v, input logic [3:0] s, input logic [1:0] u, input logic dv);
		@(posedge sys_clk);
		rstn <= 1'b0;
		fv <= v;
		src <= s;
		startup_time_fuses <= u;
		div <= dv;
		repeat (4) @(posedge sys_clk);
		rstn <= 1'b1;
		repeat (40) @(posedge sys_clk);
		@(negedge sys_clk);
		chk("early_en", en, 0);
	endtask
	task waitup(input logic must);
		for (n = 0; n < 900 && en !== 1'b1; n++) @(negedge sys_clk);
		if (must && n == 900) begin
			err_count++;
			print_verdict;
		end
	endtask
	initial begin
		boot(1'b0, 4'hf, 2'h3, 1'b1);
		chk("trim_rst", trim, 7'h40);
		chk("wdt", wdt, 1);
		chk("dflt", {lf, rc, ext, d8, tp}, 5'h0b);
		wb(1'b0, 4'h4, 0);
		chk("status", rd, 32'h2252);
		waitup(1'b1);
		wb(1'b0, 4'h4, 0);
		chk("ready", rd, 32'h2253);
		for (i = 0; i < 3; i++) begin
			wb(1'b1, 4'h0, tv[i]);
			chk("trim_out", trim, tv[i][6:0]);
			wb(1'b0, 4'h0, 0);
			chk("trim_rd", rd, {25'h0, tv[i][6:0]});
		end
		wb(1'b1, 4'h4, 0);
		wb(1'b0, 4'h4, 0);
		chk("status_ro", rd, 32'h2253);
		wb(1'b0, 4'hc, 0);
		chk("unm_err", be, 1);
		chk("unm_dat", rd, 0);
		wb(1'b1, 4'h8, 1);
		@(negedge sys_clk);
		chk("wake_en", en, 0);
		wb(1'b0, 4'h8, 0);
		chk("wake_clr", rd, 0);
		waitup(1'b1);
		chk("wake_done", en, 1);
		for (i = 0; i < 6; i++) begin
			boot(1'b1, cs[i], cu[i], i == 5);
			chk("trim_rst", trim, 7'h40);
			chk("sel", {lf, rc, ext, d8, tp}, {ce[i], ce[i][1] && i != 5, ce[i][1]});
			wb(1'b0, 4'h4, 0);
			chk("codes", rd[13:8], {cu[i], cs[i]});
			waitup(cs[i] != 4'h3);
			chk("en", en, cs[i] != 4'h3);
		end
		print_verdict;
	end
endmodule
